//--- rtl/ptr_unit_pkg.sv
`default_nettype none
package ptr_unit_pkg;
	// address and data widths
	localparam int ADDR_W = 12;
	localparam int HIGH_W = 4;
	localparam int DATA_W = 8;
	localparam int REG_AW = 8;
	localparam int NUM_PTR = 3;

	// register port map: each pointer owns an eight-address slot
	localparam logic [1:0] SLOT_WORKING_REGISTER = 2'h3;
	localparam logic [2:0] SUB_PLAIN = 3'h0;
	localparam logic [2:0] SUB_POST_INC = 3'h1;
	localparam logic [2:0] SUB_POST_DEC = 3'h2;
	localparam logic [2:0] SUB_PRE_INC = 3'h3;
	localparam logic [2:0] SUB_INDEXED = 3'h4;
	localparam logic [2:0] SUB_LOW = 3'h5;
	localparam logic [2:0] SUB_HIGH = 3'h6;
	localparam logic [7:0] ADDR_WORKING_REGISTER = 8'h18;

	// field positions inside a register address
	localparam int SLOT_LSB = 3;
	localparam int TOP_LSB = 5;

	// reset values and read-back constants
	localparam logic [HIGH_W-1:0] HIGH_RESET = 4'h0;
	localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

	// how a selector moves its pointer
	typedef enum logic [2:0] {
		MODE_PLAIN,
		MODE_POST_INC,
		MODE_POST_DEC,
		MODE_PRE_INC,
		MODE_INDEXED
	} sel_mode_e;

	// one decoded data memory access
	typedef struct packed {
		logic valid;
		logic write;
		logic [1:0] idx;
		sel_mode_e mode;
	} access_s;

	// whole state of the pointer unit
	typedef struct packed {
		logic [NUM_PTR-1:0][HIGH_W-1:0] high;
		logic [NUM_PTR-1:0][DATA_W-1:0] low;
		logic [DATA_W-1:0] working_register;
		logic rd_mem;
		logic [DATA_W-1:0] rd_data;
	} unit_state_s;
endpackage
`default_nettype wire

//--- rtl/ptr_calc.sv
`default_nettype none
module ptr_calc #(
	parameter int AW = 12,
	parameter int DW = 8
) (
	input wire logic [AW-1:0] ptr,
	input wire ptr_unit_pkg::sel_mode_e mode,
	input wire logic [DW-1:0] working_register,
	output logic [AW-1:0] acc_addr,
	output logic [AW-1:0] next_ptr
);
	logic [AW-1:0] offset;

	// working register sign-extended to the address width
	assign offset = {{(AW-DW){working_register[DW-1]}}, working_register};

	// access address and pointer update, all modulo the address width
	always_comb begin
		acc_addr = ptr;
		next_ptr = ptr;
		unique case (mode)
			ptr_unit_pkg::MODE_PLAIN: begin
				acc_addr = ptr;
			end
			ptr_unit_pkg::MODE_POST_INC: begin
				next_ptr = AW'(ptr + 1'b1);
			end
			ptr_unit_pkg::MODE_POST_DEC: begin
				next_ptr = AW'(ptr - 1'b1);
			end
			ptr_unit_pkg::MODE_PRE_INC: begin
				acc_addr = AW'(ptr + 1'b1);
				next_ptr = AW'(ptr + 1'b1);
			end
			ptr_unit_pkg::MODE_INDEXED: begin
				acc_addr = AW'(ptr + offset);
			end
			default: begin
				acc_addr = ptr;
			end
		endcase
	end
endmodule // ptr_calc
`default_nettype wire

//--- rtl/data_mem.sv
`default_nettype none
module data_mem #(
	parameter int AW = 12,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [2**AW];

	// storage writes; contents are not cleared by reset
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	// registered read port
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata <= '0;
		end else begin
			rdata <= mem[addr];
		end
	end
endmodule // data_mem
`default_nettype wire

//--- rtl/indirect_data_pointer_unit.sv
// The implementer's own choices: the plain strobed port and the register addresses.
`default_nettype none
module indirect_data_pointer_unit #(
	parameter int AW = ptr_unit_pkg::ADDR_W,
	parameter int DW = ptr_unit_pkg::DATA_W
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [ptr_unit_pkg::REG_AW-1:0] reg_addr,
	input wire logic [DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DW-1:0] reg_rdata
);
	localparam int NP = ptr_unit_pkg::NUM_PTR;
	localparam int HW = ptr_unit_pkg::HIGH_W;

	ptr_unit_pkg::unit_state_s s;
	ptr_unit_pkg::unit_state_s next_s;
	ptr_unit_pkg::access_s acc;
	logic [NP-1:0][AW-1:0] cur_ptr;
	logic [NP-1:0][AW-1:0] calc_addr;
	logic [NP-1:0][AW-1:0] calc_next;
	logic [AW-1:0] mem_addr;
	logic [DW-1:0] mem_q;

	// decode a register address into a selector access
	function automatic ptr_unit_pkg::access_s decode_sel(
		input logic [ptr_unit_pkg::REG_AW-1:0] a,
		input logic wr,
		input logic rd
	);
		ptr_unit_pkg::access_s r;
		r.valid = 1'b0;
		r.write = wr;
		r.idx = a[ptr_unit_pkg::TOP_LSB-1:ptr_unit_pkg::SLOT_LSB];
		r.mode = ptr_unit_pkg::MODE_PLAIN;
		if ((wr || rd) && a[ptr_unit_pkg::REG_AW-1:ptr_unit_pkg::TOP_LSB] == '0
			&& r.idx != ptr_unit_pkg::SLOT_WORKING_REGISTER) begin
			r.valid = 1'b1;
			unique case (a[ptr_unit_pkg::SLOT_LSB-1:0])
				ptr_unit_pkg::SUB_PLAIN: r.mode = ptr_unit_pkg::MODE_PLAIN;
				ptr_unit_pkg::SUB_POST_INC: r.mode = ptr_unit_pkg::MODE_POST_INC;
				ptr_unit_pkg::SUB_POST_DEC: r.mode = ptr_unit_pkg::MODE_POST_DEC;
				ptr_unit_pkg::SUB_PRE_INC: r.mode = ptr_unit_pkg::MODE_PRE_INC;
				ptr_unit_pkg::SUB_INDEXED: r.mode = ptr_unit_pkg::MODE_INDEXED;
				default: r.valid = 1'b0;
			endcase
		end
		return r;
	endfunction

	// true when the address names a stored register of a pointer slot
	function automatic logic is_ptr_reg(
		input logic [ptr_unit_pkg::REG_AW-1:0] a,
		input logic [2:0] sub
	);
		return a[ptr_unit_pkg::REG_AW-1:ptr_unit_pkg::TOP_LSB] == '0
			&& a[ptr_unit_pkg::TOP_LSB-1:ptr_unit_pkg::SLOT_LSB]
			!= ptr_unit_pkg::SLOT_WORKING_REGISTER
			&& a[ptr_unit_pkg::SLOT_LSB-1:0] == sub;
	endfunction

	assign acc = decode_sel(reg_addr, reg_wr, reg_rd);

	// full pointer values and per-pointer address arithmetic
	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++) begin : g_ptr
			assign cur_ptr[gi] = {s.high[gi], s.low[gi]};
			ptr_calc #(
				.AW(AW),
				.DW(DW)
			) u_calc (
				.ptr(cur_ptr[gi]),
				.mode(acc.mode),
				.working_register(s.working_register),
				.acc_addr(calc_addr[gi]),
				.next_ptr(calc_next[gi])
			);
		end
	endgenerate

	// idle address when no selector is hit, so no index runs past the pointers
	assign mem_addr = acc.valid ? calc_addr[acc.idx] : '0;

	// data memory reached only through the selectors
	data_mem #(
		.AW(AW),
		.DW(DW)
	) u_mem (
		.clk(clk),
		.srst(srst),
		.we(acc.valid && acc.write),
		.addr(mem_addr),
		.wdata(reg_wdata),
		.rdata(mem_q)
	);

	// next state: selector access, register write, read capture
	always_comb begin
		next_s = s;
		next_s.rd_mem = 1'b0;
		next_s.rd_data = ptr_unit_pkg::READ_IDLE;
		if (acc.valid) begin
			// selectors hold no data; only the pointer moves
			{next_s.high[acc.idx], next_s.low[acc.idx]} =
				calc_next[acc.idx];
			next_s.rd_mem = !acc.write;
		end else if (reg_wr) begin
			if (reg_addr == ptr_unit_pkg::ADDR_WORKING_REGISTER) begin
				next_s.working_register = reg_wdata;
			end else if (is_ptr_reg(reg_addr, ptr_unit_pkg::SUB_LOW)) begin
				next_s.low[reg_addr[4:3]] = reg_wdata;
			end else if (is_ptr_reg(reg_addr, ptr_unit_pkg::SUB_HIGH)) begin
				next_s.high[reg_addr[4:3]] = reg_wdata[HW-1:0];
			end
		end else if (reg_rd) begin
			if (reg_addr == ptr_unit_pkg::ADDR_WORKING_REGISTER) begin
				next_s.rd_data = s.working_register;
			end else if (is_ptr_reg(reg_addr, ptr_unit_pkg::SUB_LOW)) begin
				next_s.rd_data = s.low[reg_addr[4:3]];
			end else if (is_ptr_reg(reg_addr, ptr_unit_pkg::SUB_HIGH)) begin
				// unimplemented upper bits read as zero
				next_s.rd_data = {{(DW-HW){1'b0}}, s.high[reg_addr[4:3]]};
			end
		end
		if (srst) begin
			// low bytes and working register keep whatever they hold
			for (int i = 0; i < NP; i++) begin
				next_s.high[i] = ptr_unit_pkg::HIGH_RESET;
			end
			next_s.rd_mem = 1'b0;
			next_s.rd_data = ptr_unit_pkg::READ_IDLE;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		s <= next_s;
	end

	// read data in the cycle after the read strobe
	assign reg_rdata = s.rd_mem ? mem_q : s.rd_data;

	// helper signals for the checks below: copies of the previous access and current-cycle values
	logic [1:0] last_idx;
	logic [AW-1:0] last_addr;
	logic [AW-1:0] sel_ptr;
	logic [AW-1:0] sext_w;
	logic [1:0] reg_slot;
	always_ff @(posedge clk) begin
		last_idx <= acc.idx;
		last_addr <= mem_addr;
	end
	assign sel_ptr = acc.valid ? cur_ptr[acc.idx] : '0;
	assign sext_w = {{(AW-DW){s.working_register[DW-1]}}, s.working_register};
	// pointer slot named by the register address
	assign reg_slot =
		reg_addr[ptr_unit_pkg::TOP_LSB-1:ptr_unit_pkg::SLOT_LSB];

	// access with a given mode this cycle
	sequence s_access(ptr_unit_pkg::sel_mode_e m);
		acc.valid && acc.mode == m;
	endsequence

	// pointer of the last access holds a given value
	sequence s_ptr_is(logic [AW-1:0] v);
		cur_ptr[last_idx] == v;
	endsequence

	property p_plain;
		@(posedge clk) disable iff (srst)
		s_access(ptr_unit_pkg::MODE_PLAIN) |->
			mem_addr == sel_ptr ##1 s_ptr_is($past(sel_ptr));
	endproperty
	a_plain: assert property (p_plain)
		else $error("plain selector moved its pointer or used wrong address");

	property p_post_inc;
		@(posedge clk) disable iff (srst)
		s_access(ptr_unit_pkg::MODE_POST_INC) |->
			mem_addr == sel_ptr ##1 s_ptr_is(AW'($past(sel_ptr) + 1'b1));
	endproperty
	a_post_inc: assert property (p_post_inc)
		else $error("after-increment selector misbehaved");

	property p_post_dec;
		@(posedge clk) disable iff (srst)
		s_access(ptr_unit_pkg::MODE_POST_DEC) |->
			mem_addr == sel_ptr ##1 s_ptr_is(AW'($past(sel_ptr) - 1'b1));
	endproperty
	a_post_dec: assert property (p_post_dec)
		else $error("after-decrement selector misbehaved");

	property p_pre_inc;
		@(posedge clk) disable iff (srst)
		s_access(ptr_unit_pkg::MODE_PRE_INC) |->
			mem_addr == AW'(sel_ptr + 1'b1) ##1 s_ptr_is(last_addr);
	endproperty
	a_pre_inc: assert property (p_pre_inc)
		else $error("before-increment selector misbehaved");

	property p_indexed;
		@(posedge clk) disable iff (srst)
		s_access(ptr_unit_pkg::MODE_INDEXED) |->
			mem_addr == AW'(sel_ptr + sext_w)
			##1 (s_ptr_is($past(sel_ptr)) and s.working_register == $past(s.working_register));
	endproperty
	a_indexed: assert property (p_indexed)
		else $error("indexed selector used wrong address or changed state");

	property p_others_still;
		@(posedge clk) disable iff (srst)
		acc.valid |=> cur_ptr[(last_idx == 2'h0) ? 1 : 0]
			== $past(cur_ptr[(acc.idx == 2'h0) ? 1 : 0])
			&& s.working_register == $past(s.working_register);
	endproperty
	a_others_still: assert property (p_others_still)
		else $error("selector access disturbed another pointer");

	property p_high_reset;
		@(posedge clk)
		srst |=> s.high[0] == '0 && s.high[1] == '0 && s.high[2] == '0;
	endproperty
	a_high_reset: assert property (p_high_reset)
		else $error("pointer high part not cleared by reset");

	property p_wrap;
		@(posedge clk) disable iff (srst)
		s_access(ptr_unit_pkg::MODE_POST_INC) and sel_ptr == '1
			|=> cur_ptr[last_idx] == '0;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("pointer did not wrap at the top of the address space");

	property p_working_register_write;
		@(posedge clk) disable iff (srst)
		reg_wr && reg_addr == ptr_unit_pkg::ADDR_WORKING_REGISTER
			|=> s.working_register == $past(reg_wdata);
	endproperty
	a_working_register_write: assert property (p_working_register_write)
		else $error("working register write lost");

	property p_low_read;
		@(posedge clk) disable iff (srst)
		reg_rd && is_ptr_reg(reg_addr, ptr_unit_pkg::SUB_LOW)
			|=> reg_rdata == $past(s.low[reg_addr[4:3]]);
	endproperty
	a_low_read: assert property (p_low_read)
		else $error("low byte read back wrong");

	property p_post_dec_wrap;
		@(posedge clk) disable iff (srst)
		s_access(ptr_unit_pkg::MODE_POST_DEC) and sel_ptr == '0
			|=> cur_ptr[last_idx] == '1;
	endproperty
	a_post_dec_wrap: assert property (p_post_dec_wrap)
		else $error("pointer did not wrap below address zero");

	property p_pre_inc_wrap;
		@(posedge clk) disable iff (srst)
		s_access(ptr_unit_pkg::MODE_PRE_INC) and sel_ptr == '1
			|-> mem_addr == '0 ##1 s_ptr_is('0);
	endproperty
	a_pre_inc_wrap: assert property (p_pre_inc_wrap)
		else $error("before-increment did not wrap to address zero");

	property p_high_write;
		@(posedge clk) disable iff (srst)
		reg_wr && is_ptr_reg(reg_addr, ptr_unit_pkg::SUB_HIGH)
			|=> s.high[$past(reg_slot)] == $past(reg_wdata[HW-1:0]);
	endproperty
	a_high_write: assert property (p_high_write)
		else $error("pointer high part write lost");

	property p_low_write;
		@(posedge clk) disable iff (srst)
		reg_wr && is_ptr_reg(reg_addr, ptr_unit_pkg::SUB_LOW)
			|=> s.low[$past(reg_slot)] == $past(reg_wdata);
	endproperty
	a_low_write: assert property (p_low_write)
		else $error("pointer low byte write lost");

	property p_high_read;
		@(posedge clk) disable iff (srst)
		reg_rd && is_ptr_reg(reg_addr, ptr_unit_pkg::SUB_HIGH)
			|=> reg_rdata[DW-1:HW] == '0
			&& reg_rdata[HW-1:0] == $past(s.high[reg_slot]);
	endproperty
	a_high_read: assert property (p_high_read)
		else $error("pointer high part read back wrong");

	property p_working_register_read;
		@(posedge clk) disable iff (srst)
		reg_rd && reg_addr == ptr_unit_pkg::ADDR_WORKING_REGISTER
			|=> reg_rdata == $past(s.working_register);
	endproperty
	a_working_register_read: assert property (p_working_register_read)
		else $error("working register read back wrong");

	property p_unmapped_read;
		@(posedge clk) disable iff (srst)
		reg_rd && reg_addr[ptr_unit_pkg::REG_AW-1:ptr_unit_pkg::TOP_LSB] != '0
			|=> reg_rdata == ptr_unit_pkg::READ_IDLE;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped address read gave data");

	property p_idle_read;
		@(posedge clk) disable iff (srst)
		!reg_rd |=> reg_rdata == ptr_unit_pkg::READ_IDLE;
	endproperty
	a_idle_read: assert property (p_idle_read)
		else $error("read data showed without a read strobe");

	// plain selector write this cycle
	sequence s_plain_write;
		acc.valid && acc.write && acc.mode == ptr_unit_pkg::MODE_PLAIN;
	endsequence

	// plain selector read of the pointer used one cycle before
	sequence s_plain_read_same;
		acc.valid && !acc.write && acc.mode == ptr_unit_pkg::MODE_PLAIN
			&& acc.idx == last_idx;
	endsequence

	property p_store_through;
		@(posedge clk) disable iff (srst)
		s_plain_write ##1 s_plain_read_same
			|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_store_through: assert property (p_store_through)
		else $error("data written through a selector did not read back");
endmodule // indirect_data_pointer_unit
`default_nettype wire

//--- dv/core_access_model.sv
`default_nettype none
module core_access_model (
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	timeunit 1ns;
	timeprecision 1ps;

	// bus idle from time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// one strobe cycle launched just after a rising edge
	task automatic access(input logic [7:0] a, input logic w,
		input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
	endtask

	// drop both strobes
	task automatic idle();
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask
endmodule // core_access_model
`default_nettype wire

//--- dv/indirect_data_pointer_unit_tb_top.sv
`default_nettype none
module indirect_data_pointer_unit_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk;
	logic srst = 1'b1;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic rd_seen = 1'b0;
	logic [8:0] n;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	logic [11:0] ptr [3];
	logic [7:0] working_register;
	logic [7:0] mem [int];
	logic [8:0] notes [$];

	indirect_data_pointer_unit u_indirect_data_pointer_unit (
		.clk(clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	core_access_model u_core_access_model (.clk(clk),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd));

	// free running clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// expected-state update, note for reads, then the bus cycle
	task automatic op(input int i, input logic [2:0] s, input logic w,
		input logic [7:0] d);
		logic [11:0] a;
		logic [7:0] e;
		logic k;
		a = (i < 3) ? ptr[i] : 12'h000;
		e = 8'h00;
		k = 1'b1;
		if (i == 3 && s == 3'h0) begin
			e = working_register;
			if (w) working_register = d;
		end else if (i > 2 || s == 3'h7) begin
			e = 8'h00;
		end else if (s == 3'h5) begin
			e = a[7:0];
			if (w) ptr[i][7:0] = d;
		end else if (s == 3'h6) begin
			e = {4'h0, a[11:8]};
			if (w) ptr[i][11:8] = d[3:0];
		end else begin
			if (s == 3'h1 || s == 3'h3) ptr[i] = a + 12'h001;
			if (s == 3'h2) ptr[i] = a - 12'h001;
			if (s == 3'h3) a = ptr[i];
			if (s == 3'h4) a = a + {{4{working_register[7]}}, working_register};
			k = mem.exists(a);
			if (k) e = mem[a];
			if (w) mem[a] = d;
		end
		if (!w) notes.push_back({k, e});
		u_core_access_model.access(8'(i * 8 + s), w, d);
	endtask

	task automatic do_reset();
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 3; i++) ptr[i][11:8] = 4'h0;
	endtask

	// read results one cycle after the read, idle zero otherwise
	always @(posedge clk) begin
		if (rd_seen) begin
			n = notes.pop_front();
			if (n[8]) check("read data", n[7:0], reg_rdata);
		end else if (!srst && cyc > 3) begin
			check("idle read data", 8'h00, reg_rdata);
		end
		rd_seen <= reg_rd && !srst;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			close_out();
		end
	end

	// main sequence
	initial begin
		void'($urandom(32'hD794));
		do_reset();
		for (int i = 0; i < 3; i++) op(i, 3'h6, 1'b0, 8'h00);
		for (int i = 0; i < 3; i++) op(i, 3'h5, 1'b1, 8'(i));
		op(3, 3'h0, 1'b1, 8'h80);
		op(3, 3'h0, 1'b0, 8'h00);
		op(0, 3'h5, 1'b1, 8'hFF);
		op(0, 3'h6, 1'b1, 8'hFF);
		op(0, 3'h6, 1'b0, 8'h00);
		op(0, 3'h1, 1'b1, 8'hA5);
		op(0, 3'h2, 1'b1, 8'h3C);
		op(0, 3'h3, 1'b0, 8'h00);
		op(0, 3'h0, 1'b0, 8'h00);
		op(0, 3'h2, 1'b0, 8'h00);
		op(0, 3'h0, 1'b0, 8'h00);
		op(0, 3'h5, 1'b0, 8'h00);
		op(1, 3'h5, 1'b1, 8'h05);
		op(1, 3'h6, 1'b1, 8'hF0);
		op(1, 3'h4, 1'b1, 8'h77);
		op(1, 3'h0, 1'b1, 8'h5A);
		op(1, 3'h0, 1'b0, 8'h00);
		op(2, 3'h5, 1'b1, 8'h85);
		op(2, 3'h6, 1'b1, 8'h0F);
		op(2, 3'h0, 1'b0, 8'h00);
		op(1, 3'h5, 1'b0, 8'h00);
		op(3, 3'h0, 1'b0, 8'h00);
		op(0, 3'h7, 1'b1, 8'h11);
		op(0, 3'h7, 1'b0, 8'h00);
		op(5, 3'h2, 1'b0, 8'h00);
		for (int j = 0; j < 2000; j++) begin
			op($urandom_range(4), 3'($urandom_range(7)), 1'($urandom),
				8'($urandom));
		end
		u_core_access_model.idle();
		do_reset();
		for (int i = 0; i < 3; i++) op(i, 3'h6, 1'b0, 8'h00);
		u_core_access_model.idle();
		repeat (3) @(posedge clk);
		close_out();
	end
endmodule // indirect_data_pointer_unit_tb_top
`default_nettype wire
